// ==== verilog/rtig_pkg.sv ====
package rtig_pkg;

   // Register byte addresses
   localparam logic [7:0] REG_CONFIG  = 8'h00;
   localparam logic [7:0] REG_MASK    = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_STATE   = 8'h0c;

   // Interrupt select field positions
   localparam int SEL_FIELD_EN  = 0;
   localparam int SEL_RF_SRC    = 1;
   localparam int SEL_RF_EN     = 2;
   localparam int SEL_W         = 3;

   // Status and mask bit positions
   localparam int EVT_FIELD = 0;
   localparam int EVT_RF    = 1;
   localparam int EVT_W     = 2;

   // Live state bit positions
   localparam int ST_FIELD   = 0;
   localparam int ST_CONTACT = 1;
   localparam int ST_POWERED = 2;

   // Reset values
   localparam logic [2:0] CONFIG_RST = 3'h0;
   localparam logic [1:0] MASK_RST   = 2'h0;
   localparam logic [1:0] STATUS_RST = 2'h0;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verilog/rtig_top.sv ====
`timescale 1ns/10ps
module rtig_top #(
   parameter int         ADDR_W     = 8,
   parameter logic [0:0] SRC_TX_VAL = 1'h0
) (
   input  wire  logic              aclk,
   input  wire  logic              aresetn,
   input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire  logic              s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire  logic [31:0]       s_axi_wdata,
   input  wire  logic [3:0]        s_axi_wstrb,
   input  wire  logic              s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire  logic              s_axi_bready,
   input  wire  logic [ADDR_W-1:0] s_axi_araddr,
   input  wire  logic              s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire  logic              s_axi_rready,
   input  wire  logic              rf_tx_done,
   input  wire  logic              rf_mem_wr_done,
   input  wire  logic              field_detect,
   input  wire  logic              contact_supply,
   output logic                    irq,
   input  wire  logic              interrupt_out_n_i,
   output logic                    interrupt_out_n_o,
   output logic                    interrupt_out_n_oe
);

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_have;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [2:0]        cfg;
      logic [1:0]        mask;
      logic [1:0]        status;
      logic              field_q;
      logic              powered;
      logic              irq;
      logic              pin_oe;
   } rtig_state_t;

   rtig_state_t s_q;
   rtig_state_t s_d;

   logic       powered;
   logic       rf_evt;
   logic       field_evt;
   logic [1:0] evt;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = 8'(a);
      mapped = (b == rtig_pkg::REG_CONFIG) || (b == rtig_pkg::REG_MASK)
            || (b == rtig_pkg::REG_STATUS) || (b == rtig_pkg::REG_STATE);
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        r);
      hit = (8'(a) == r);
   endfunction

   // Tag runs either from the contact supply or from the field
   assign powered = contact_supply | field_detect;

   always_comb begin
      if (s_q.cfg[rtig_pkg::SEL_RF_SRC] == SRC_TX_VAL) begin
         rf_evt = rf_tx_done;
      end else begin
         rf_evt = rf_mem_wr_done;
      end
   end

   assign field_evt = field_detect & ~s_q.field_q;

   always_comb begin
      evt = 2'h0;
      evt[rtig_pkg::EVT_RF] = rf_evt
         & s_q.cfg[rtig_pkg::SEL_RF_EN];
      evt[rtig_pkg::EVT_FIELD] = field_evt
         & s_q.cfg[rtig_pkg::SEL_FIELD_EN];
   end

   always_comb begin
      s_d = s_q;
      s_d.field_q = field_detect;
      s_d.powered = powered;

      // Write address and data are taken independently
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_d.aw_have && s_d.w_have && !s_d.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = mapped(s_d.aw_addr) ? rtig_pkg::RESP_OKAY
                                           : rtig_pkg::RESP_SLVERR;
         if (s_d.w_strb[0]) begin
            if (hit(s_d.aw_addr, rtig_pkg::REG_CONFIG)) begin
               s_d.cfg = s_d.w_data[rtig_pkg::SEL_W-1:0];
            end
            if (hit(s_d.aw_addr, rtig_pkg::REG_MASK)) begin
               s_d.mask = s_d.w_data[rtig_pkg::EVT_W-1:0];
            end
         end
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready  = !s_d.w_have && !s_d.bvalid;

      // Read channel; a status read clears it
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = 32'h0;
         s_d.rresp  = mapped(s_axi_araddr) ? rtig_pkg::RESP_OKAY
                                           : rtig_pkg::RESP_SLVERR;
         if (hit(s_axi_araddr, rtig_pkg::REG_CONFIG)) begin
            s_d.rdata[rtig_pkg::SEL_W-1:0] = s_q.cfg;
         end
         if (hit(s_axi_araddr, rtig_pkg::REG_MASK)) begin
            s_d.rdata[rtig_pkg::EVT_W-1:0] = s_q.mask;
         end
         if (hit(s_axi_araddr, rtig_pkg::REG_STATUS)) begin
            s_d.rdata[rtig_pkg::EVT_W-1:0] = s_q.status;
            s_d.status = rtig_pkg::STATUS_RST;
         end
         if (hit(s_axi_araddr, rtig_pkg::REG_STATE)) begin
            s_d.rdata[rtig_pkg::ST_FIELD]   = field_detect;
            s_d.rdata[rtig_pkg::ST_CONTACT] = contact_supply;
            s_d.rdata[rtig_pkg::ST_POWERED] = powered;
         end
      end
      s_d.arready = !s_d.rvalid;

      // New events win over a clearing read
      s_d.status = s_d.status | evt;

      // Supply lost: all pending state is gone
      if (!powered) begin
         s_d.status = rtig_pkg::STATUS_RST;
      end

      s_d.irq    = |(s_d.status & ~s_d.mask);
      s_d.pin_oe = s_d.irq && powered;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q        <= '0;
         s_q.cfg    <= rtig_pkg::CONFIG_RST;
         s_q.mask   <= rtig_pkg::MASK_RST;
         s_q.status <= rtig_pkg::STATUS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready      = s_q.awready;
   assign s_axi_wready       = s_q.wready;
   assign s_axi_bvalid       = s_q.bvalid;
   assign s_axi_bresp        = s_q.bresp;
   assign s_axi_arready      = s_q.arready;
   assign s_axi_rvalid       = s_q.rvalid;
   assign s_axi_rdata        = s_q.rdata;
   assign s_axi_rresp        = s_q.rresp;
   assign irq                = s_q.irq;
   // Open drain: only ever pulls low
   assign interrupt_out_n_o  = 1'b0;
   assign interrupt_out_n_oe = s_q.pin_oe;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_pin_follows_pend: assert property (
      s_q.pin_oe == (s_q.powered && |(s_q.status & ~s_q.mask)))
      else $error("Pin drive does not match pending interrupt");

   a_rf_tx_sets: assert property (
      (s_q.cfg[rtig_pkg::SEL_RF_EN] && rf_tx_done && powered
       && s_q.cfg[rtig_pkg::SEL_RF_SRC] == SRC_TX_VAL)
      |=> s_q.status[rtig_pkg::EVT_RF])
      else $error("Response done did not set RF status");

   a_rf_off_quiet: assert property (
      (!s_q.cfg[rtig_pkg::SEL_RF_EN]
       && !s_q.status[rtig_pkg::EVT_RF])
      |=> !s_q.status[rtig_pkg::EVT_RF])
      else $error("RF status set while RF interrupt disabled");

   a_rf_wr_sets: assert property (
      (s_q.cfg[rtig_pkg::SEL_RF_EN] && rf_mem_wr_done && powered
       && s_q.cfg[rtig_pkg::SEL_RF_SRC] != SRC_TX_VAL)
      |=> s_q.status[rtig_pkg::EVT_RF])
      else $error("Memory write done did not set RF status");

   a_rf_src_ignored: assert property (
      (s_q.cfg[rtig_pkg::SEL_RF_SRC] == SRC_TX_VAL
       && !rf_tx_done && !s_q.status[rtig_pkg::EVT_RF])
      |=> !s_q.status[rtig_pkg::EVT_RF])
      else $error("Unselected RF source set RF status");

   a_field_sets: assert property (
      (s_q.cfg[rtig_pkg::SEL_FIELD_EN] && $rose(field_detect))
      |=> s_q.status[rtig_pkg::EVT_FIELD])
      else $error("Field arrival did not set field status");

   a_field_off_quiet: assert property (
      (!s_q.cfg[rtig_pkg::SEL_FIELD_EN]
       && !s_q.status[rtig_pkg::EVT_FIELD])
      |=> !s_q.status[rtig_pkg::EVT_FIELD])
      else $error("Field status set while field interrupt disabled");

   a_mask_blocks: assert property (
      (&s_q.mask) |-> (!s_q.irq && !s_q.pin_oe))
      else $error("Masked interrupt reached the outputs");

   a_rf_power_irq: assert property (
      (!contact_supply && $rose(field_detect)
       && s_q.cfg[rtig_pkg::SEL_FIELD_EN]
       && !s_q.mask[rtig_pkg::EVT_FIELD])
      |=> interrupt_out_n_oe)
      else $error("No interrupt after power-up from the field");

   a_field_loss_off: assert property (
      (!contact_supply && !field_detect) |=> !interrupt_out_n_oe)
      else $error("Pin still driven after field power was lost");

   a_rf_wr_ignored: assert property (
      (s_q.cfg[rtig_pkg::SEL_RF_SRC] != SRC_TX_VAL
       && !rf_mem_wr_done && !s_q.status[rtig_pkg::EVT_RF])
      |=> !s_q.status[rtig_pkg::EVT_RF])
      else $error("Response done set RF status while write source chosen");

   a_rf_sticky: assert property (
      (s_q.status[rtig_pkg::EVT_RF] && powered
       && !(s_axi_arvalid && s_q.arready
            && hit(s_axi_araddr, rtig_pkg::REG_STATUS)))
      |=> s_q.status[rtig_pkg::EVT_RF])
      else $error("RF status cleared without a status read");

   a_field_sticky: assert property (
      (s_q.status[rtig_pkg::EVT_FIELD] && powered
       && !(s_axi_arvalid && s_q.arready
            && hit(s_axi_araddr, rtig_pkg::REG_STATUS)))
      |=> s_q.status[rtig_pkg::EVT_FIELD])
      else $error("Field status cleared without a status read");

   a_status_rd_clr: assert property (
      (s_axi_arvalid && s_q.arready
       && hit(s_axi_araddr, rtig_pkg::REG_STATUS)
       && !rf_tx_done && !rf_mem_wr_done && !field_detect)
      |=> (s_q.status == rtig_pkg::STATUS_RST))
      else $error("Status read did not clear the status bits");

   a_unpowered_clr: assert property (
      !powered |=> ((s_q.status == rtig_pkg::STATUS_RST) && !s_q.irq))
      else $error("Pending state kept after power was lost");

   a_irq_pin_agree: assert property (
      s_q.irq == interrupt_out_n_oe)
      else $error("Level output and pin drive disagree");

   a_pin_drives_low: assert property (
      interrupt_out_n_oe |-> !interrupt_out_n_o)
      else $error("Pin driven to a high level");

   a_mask_rf_only: assert property (
      (s_q.mask[rtig_pkg::EVT_RF] && !s_q.status[rtig_pkg::EVT_FIELD])
      |-> !s_q.irq)
      else $error("Masked RF status raised the interrupt");

   a_mask_field_only: assert property (
      (s_q.mask[rtig_pkg::EVT_FIELD] && !s_q.status[rtig_pkg::EVT_RF])
      |-> !s_q.irq)
      else $error("Masked field status raised the interrupt");

   a_unmasked_raise: assert property (
      (|(s_q.status & ~s_q.mask)) |-> s_q.irq)
      else $error("Unmasked pending status left the output low");

   // Register bus protocol checks
   a_bresp_hold: assert property (
      (s_axi_bvalid && !s_axi_bready)
      |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("Write response changed before it was taken");

   a_rdata_hold: assert property (
      (s_axi_rvalid && !s_axi_rready)
      |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
      else $error("Read answer changed before it was taken");

   a_ar_refused: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("Read address accepted while an answer is pending");

   a_aw_refused: assert property (
      s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
      else $error("Write accepted while a response is pending");

   a_rdata_upper: assert property (
      s_axi_rvalid |-> (s_axi_rdata[31:rtig_pkg::SEL_W] == '0))
      else $error("Unused read data bits are not zero");

endmodule

// ==== test/rtig_host_pin.sv ====
`timescale 1ns/10ps
module rtig_host_pin (
   input  wire logic oe,
   input  wire logic o,
   output logic      pin_n
);
   // Pull-up on the host side holds the line high once the tag lets go
   assign pin_n = oe ? o : 1'b1;
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   localparam logic [0:0] SRC = 1'h0;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h0;
   logic [7:0]  araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        tx = 1'b0;
   logic        mw = 1'b0;
   logic        fld = 1'b0;
   logic        csup = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid, irq, po, poe, pin_n;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [33:0] exp_q[$];
   logic [1:0]  bexp_q[$];
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          seed = 32'hb5be;

   rtig_top #(.ADDR_W(8), .SRC_TX_VAL(SRC)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rf_tx_done(tx), .rf_mem_wr_done(mw),
      .field_detect(fld), .contact_supply(csup), .irq(irq),
      .interrupt_out_n_i(pin_n), .interrupt_out_n_o(po),
      .interrupt_out_n_oe(poe));
   rtig_host_pin host (.oe(poe), .o(po), .pin_n(pin_n));

   always #5 aclk = ~aclk;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         n_fail++;
         stop_test();
      end
   end

   // Oldest noted bus answer is compared whenever one lands
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         chk("rdata", exp_q[0][31:0], rdata);
         chk("rresp", {30'h0, exp_q[0][33:32]}, {30'h0, rresp});
         exp_q.pop_front();
      end
      if (bvalid && bready) begin
         chk("bresp", {30'h0, bexp_q[0]}, {30'h0, bresp});
         bexp_q.pop_front();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bexp_q.push_back((a inside {rtig_pkg::REG_CONFIG, rtig_pkg::REG_MASK,
         rtig_pkg::REG_STATUS, rtig_pkg::REG_STATE}) ? rtig_pkg::RESP_OKAY
         : rtig_pkg::RESP_SLVERR);
      awaddr <= a;
      wdata <= ($random(seed) & 32'hfffffff8) | d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      exp_q.push_back({r, e});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic lvl(input logic e);
      #1;
      chk("irq", {31'h0, e}, {31'h0, irq});
      chk("pin", {31'h0, ~e}, {31'h0, pin_n});
      @(posedge aclk);
   endtask

   task automatic ev(input int k);
      if (k == 0) tx <= 1'b1;
      else mw <= 1'b1;
      @(posedge aclk);
      tx <= 1'b0;
      mw <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic field(input logic v);
      fld <= v;
      repeat (2) @(posedge aclk);
   endtask

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(rtig_pkg::REG_CONFIG, 32'h0, rtig_pkg::RESP_OKAY);
      rd(rtig_pkg::REG_MASK, 32'h0, rtig_pkg::RESP_OKAY);
      rd(8'h40, 32'h0, rtig_pkg::RESP_SLVERR);
      wr(8'h40, 32'h7);
      rd(rtig_pkg::REG_CONFIG, 32'h0, rtig_pkg::RESP_OKAY);
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 2; k++) begin
            wr(rtig_pkg::REG_CONFIG, 32'h4 | (s << 1));
            ev(k);
            lvl((s == SRC) == (k == 0));
            rd(rtig_pkg::REG_STATUS, ((s == SRC) == (k == 0)) ? 2 : 0,
               rtig_pkg::RESP_OKAY);
            lvl(1'b0);
         end
      end
      wr(rtig_pkg::REG_CONFIG, 32'h1);
      ev(0);
      ev(1);
      lvl(1'b0);
      wr(rtig_pkg::REG_MASK, 32'h1);
      field(1'b1);
      lvl(1'b0);
      rd(rtig_pkg::REG_MASK, 32'h1, rtig_pkg::RESP_OKAY);
      rd(rtig_pkg::REG_STATUS, 32'h1, rtig_pkg::RESP_OKAY);
      wr(rtig_pkg::REG_MASK, 32'h2);
      field(1'b0);
      field(1'b1);
      lvl(1'b1);
      rd(rtig_pkg::REG_STATUS, 32'h1, rtig_pkg::RESP_OKAY);
      wr(rtig_pkg::REG_CONFIG, 32'h4 | (SRC << 1));
      ev(0);
      lvl(1'b0);
      rd(rtig_pkg::REG_STATUS, 32'h2, rtig_pkg::RESP_OKAY);
      field(1'b0);
      field(1'b1);
      lvl(1'b0);
      wr(rtig_pkg::REG_CONFIG, 32'h1);
      wr(rtig_pkg::REG_MASK, 32'h0);
      field(1'b0);
      csup <= 1'b0;
      field(1'b1);
      lvl(1'b1);
      field(1'b0);
      lvl(1'b0);
      rd(rtig_pkg::REG_STATUS, 32'h0, rtig_pkg::RESP_OKAY);
      csup <= 1'b1;
      rd(rtig_pkg::REG_STATE, 32'h6, rtig_pkg::RESP_OKAY);
      stop_test();
   end
endmodule
